/* File: admin_cmd_map.svh */
// Purpose: register offsets, field positions, codes and reset values
// Assumes: included by bare name from the design files
// Notes:   definitions only
`ifndef ADMIN_CMD_MAP_SVH
`define ADMIN_CMD_MAP_SVH

// ==========================================================================
// register offsets (byte addresses in the memory-mapped window)
`define INTR_ENABLE_OFF     12'h088
`define INTR_REASON_OFF     12'h098
`define CMD_WORD_OFF        12'h0a0
`define CMD_STATUS_OFF      12'h0a8
`define FAULT_LOG_OFF       12'h0c0
`define REG_ADDR_W          12

// ==========================================================================
// command word fields
`define CMD_IRQ_BIT         31
`define CMD_CODE_HI         24
`define CMD_CODE_LO         20
`define CMD_OPND_HI         19
`define CMD_OPND_LO         0
`define OPND_WQ_NUM_HI      7
`define OPND_GROUP_HI       19
`define OPND_GROUP_LO       16
`define OPND_BITMAP_HI      15
`define WQ_GROUP_HI         7
`define WQ_GROUP_LO         4
`define WQ_MEMBER_HI        3

// ==========================================================================
// command codes
`define CODE_ENABLE_DEV     5'h01
`define CODE_DISABLE_DEV    5'h02
`define CODE_DRAIN_ALL      5'h03
`define CODE_ABORT_ALL      5'h04
`define CODE_RESET_DEV      5'h05
`define CODE_ENABLE_WQ      5'h06
`define CODE_DISABLE_WQ     5'h07
`define CODE_DRAIN_WQ       5'h08
`define CODE_ABORT_WQ       5'h09

// ==========================================================================
// interrupt_reason bit positions
`define RSN_SW_ERROR        0
`define RSN_CMD_DONE        1
`define RSN_OCCUPANCY       2
`define RSN_PERF_OVF        3
`define RSN_HALT            4
`define RSN_EVENT_LOG       5
`define RSN_REVOKED         31
`define RSN_LOW_W           6

// interrupt enable bits
`define IEN_SW_ERROR        0
`define IEN_HALT            1
`define IEN_EVENT_LOG       2
`define IEN_W               3

// command status and fault log fields
`define STS_ACTIVE_BIT      31
`define STS_ERR_W           8
`define ERR_NONE            8'h00
`define ERR_UNSUPPORTED     8'h01
`define FAULT_VALID_BIT     0
`define FAULT_CODE_LO       8
`define FAULT_CMD_BUSY      8'h01

// reset values
`define ZERO_WORD           32'h0000_0000

`endif

/* File: admin_cmd_pkg.sv */
// Purpose: shared types of the admin command block
// Assumes: nothing
// Notes:   constants live in admin_cmd_map.svh
package admin_cmd_pkg;

    // ======================================================================
    // sequencer states, gray along idle-exec-wait-done
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } seq_state_type;

    // ======================================================================
    // work handed to the drain/abort engine
    typedef enum logic [1:0] {
        ENG_DRAIN_ALL = 2'b00,
        ENG_ABORT_ALL = 2'b01,
        ENG_DRAIN_WQ  = 2'b10,
        ENG_ABORT_WQ  = 2'b11
    } engine_op_type;

endpackage : admin_cmd_pkg

/* File: wq_select.sv */
// Purpose: expand a command operand into a per-work-queue selection mask
// Assumes: operand layout of the command word
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "admin_cmd_map.svh"

module wq_select #(
    parameter int NUM_WQ = 16
) (
    // operand in
    input  wire logic              i_single,
    input  wire logic [19:0]       i_operand,
    // mask out
    output var  logic [NUM_WQ-1:0] o_mask
);

    // ======================================================================
    // one comparator per queue
    genvar g;
    generate
        for (g = 0; g < NUM_WQ; g++) begin : g_wq
            localparam logic [7:0] WQ_NUM = 8'(g);
            always_comb begin
                if (i_single) begin
                    o_mask[g] = (i_operand[`OPND_WQ_NUM_HI:0] == WQ_NUM);
                end else begin
                    // group shares wq number bits 7:4, bitmap picks bits 3:0
                    o_mask[g] = (i_operand[`OPND_GROUP_HI:`OPND_GROUP_LO]
                                 == WQ_NUM[`WQ_GROUP_HI:`WQ_GROUP_LO])
                              && i_operand[WQ_NUM[`WQ_MEMBER_HI:0]];
                end
            end
        end
    endgenerate

endmodule : wq_select
`default_nettype wire

/* File: admin_command_and_irq_cause.sv */
// Purpose: admin command front end and interrupt reason register
// Assumes: single 25 MHz clock, synchronous active-low reset
// Notes:   drain/abort work is done by an outside engine
`timescale 1ns/1ps
`default_nettype none
`include "admin_cmd_map.svh"

module admin_command_and_irq_cause #(
    parameter int NUM_WQ = 16
) (
    // clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_rstn,
    // register access
    input  wire logic                        i_reg_wr,
    input  wire logic                        i_reg_rd,
    input  wire logic [`REG_ADDR_W-1:0]      i_reg_addr,
    input  wire logic [31:0]                 i_reg_wdata,
    output var  logic [31:0]                 o_reg_rdata,
    output var  logic                        o_reg_rvalid,
    // reason sources from elsewhere in the device
    input  wire logic                        i_evt_event_log,
    input  wire logic                        i_evt_halt,
    input  wire logic                        i_evt_perf_ovf,
    input  wire logic                        i_evt_occupancy,
    input  wire logic                        i_evt_revoked,
    // drain and abort engine
    output var  logic                        o_engine_req,
    output var  admin_cmd_pkg::engine_op_type o_engine_op,
    output var  logic [NUM_WQ-1:0]           o_wq_mask,
    input  wire logic                        i_engine_done,
    // device state
    output var  logic                        o_device_enabled,
    output var  logic [NUM_WQ-1:0]           o_wq_enabled,
    output var  logic                        o_config_clear,
    // message interrupt on table entry zero
    output var  logic                        o_msix0_req
);
    import admin_cmd_pkg::*;

    // ======================================================================
    // state
    typedef struct packed {
        seq_state_type         seq;
        logic                  active;
        logic [`STS_ERR_W-1:0] err;
        logic                  irq_req;
        logic [4:0]            code;
        logic [19:0]           operand;
        logic                  reason_hi;
        logic [`RSN_LOW_W-1:0] reason_lo;
        logic [`IEN_W-1:0]     ien;
        logic                  fault_valid;
        logic [`STS_ERR_W-1:0] fault_code;
        logic                  dev_en;
        logic [NUM_WQ-1:0]     wq_en;
        logic [31:0]           rdata;
        logic                  rvalid;
        logic                  engine_req;
        engine_op_type         engine_op;
        logic [NUM_WQ-1:0]     wq_mask;
        logic                  cfg_clear;
        logic                  msix;
    } state_type;

    state_type s_q;
    state_type s_d;

    // ======================================================================
    // decode helpers
    function automatic logic hit(input logic [`REG_ADDR_W-1:0] a,
                                 input logic [`REG_ADDR_W-1:0] off);
        hit = (a == off);
    endfunction : hit

    function automatic logic known_code(input logic [4:0] c);
        known_code = (c >= `CODE_ENABLE_DEV) && (c <= `CODE_ABORT_WQ);
    endfunction : known_code

    // ======================================================================
    // queue selection for the latched operand
    logic [NUM_WQ-1:0] sel_mask;

    wq_select #(
        .NUM_WQ    (NUM_WQ)
    ) i_wq_select (
        .i_single  (s_q.code == `CODE_ENABLE_WQ),
        .i_operand (s_q.operand),
        .o_mask    (sel_mask)
    );

    // ======================================================================
    // next state
    logic                  wr_cmd;
    logic                  wr_reason;
    logic                  wr_fault;
    logic                  fault_rise;
    logic                  cmd_done_evt;
    logic                  any_new;
    logic [`RSN_LOW_W-1:0] set_lo;
    logic [`RSN_LOW_W-1:0] clr_lo;

    always_comb begin
        s_d            = s_q;
        s_d.engine_req = 1'b0;
        s_d.cfg_clear  = 1'b0;
        s_d.msix       = 1'b0;
        s_d.rvalid     = 1'b0;
        cmd_done_evt   = 1'b0;
        set_lo         = '0;
        clr_lo         = '0;
        any_new        = 1'b0;

        wr_cmd    = i_reg_wr && hit(i_reg_addr, `CMD_WORD_OFF);
        wr_reason = i_reg_wr && hit(i_reg_addr, `INTR_REASON_OFF);
        wr_fault  = i_reg_wr && hit(i_reg_addr, `FAULT_LOG_OFF);

        // software registers
        if (i_reg_wr && hit(i_reg_addr, `INTR_ENABLE_OFF)) begin
            s_d.ien = i_reg_wdata[`IEN_W-1:0];
        end
        if (wr_fault && i_reg_wdata[`FAULT_VALID_BIT]) begin
            s_d.fault_valid = 1'b0;
        end

        // command acceptance; reserved bits 30:25 are not checked
        if (wr_cmd) begin
            if (s_q.active) begin
                // dropped whole; busy write logged instead
                s_d.fault_valid = 1'b1;
                s_d.fault_code  = `FAULT_CMD_BUSY;
            end else begin
                s_d.active  = 1'b1;
                s_d.irq_req = i_reg_wdata[`CMD_IRQ_BIT];
                s_d.code    = i_reg_wdata[`CMD_CODE_HI:`CMD_CODE_LO];
                s_d.operand = i_reg_wdata[`CMD_OPND_HI:`CMD_OPND_LO];
                s_d.seq     = ST_EXEC;
            end
        end

        // command sequencer
        unique case (s_q.seq)
            ST_IDLE: begin
            end
            ST_EXEC: begin
                s_d.seq = ST_DONE;
                s_d.err = `ERR_NONE;
                if (!known_code(s_q.code)) begin
                    s_d.err = `ERR_UNSUPPORTED;
                end else begin
                    unique case (s_q.code)
                        `CODE_ENABLE_DEV: begin
                            s_d.dev_en = 1'b1;
                        end
                        `CODE_DISABLE_DEV: begin
                            s_d.dev_en = 1'b0;
                            s_d.wq_en  = '0;
                        end
                        `CODE_RESET_DEV: begin
                            s_d.dev_en    = 1'b0;
                            s_d.wq_en     = '0;
                            s_d.cfg_clear = 1'b1;
                        end
                        `CODE_ENABLE_WQ: begin
                            s_d.wq_en = s_q.wq_en | sel_mask;
                        end
                        `CODE_DISABLE_WQ: begin
                            s_d.wq_en = s_q.wq_en & ~sel_mask;
                        end
                        `CODE_DRAIN_ALL: begin
                            s_d.engine_req = 1'b1;
                            s_d.engine_op  = ENG_DRAIN_ALL;
                            s_d.wq_mask    = '1;
                            s_d.seq        = ST_WAIT;
                        end
                        `CODE_ABORT_ALL: begin
                            s_d.engine_req = 1'b1;
                            s_d.engine_op  = ENG_ABORT_ALL;
                            s_d.wq_mask    = '1;
                            s_d.seq        = ST_WAIT;
                        end
                        `CODE_DRAIN_WQ: begin
                            s_d.engine_req = 1'b1;
                            s_d.engine_op  = ENG_DRAIN_WQ;
                            s_d.wq_mask    = sel_mask;
                            s_d.seq        = ST_WAIT;
                        end
                        default: begin
                            s_d.engine_req = 1'b1;
                            s_d.engine_op  = ENG_ABORT_WQ;
                            s_d.wq_mask    = sel_mask;
                            s_d.seq        = ST_WAIT;
                        end
                    endcase
                end
            end
            ST_WAIT: begin
                // engine owns the timing; no timeout is imposed
                if (i_engine_done) begin
                    s_d.seq = ST_DONE;
                end
            end
            ST_DONE: begin
                s_d.active   = 1'b0;
                s_d.seq      = ST_IDLE;
                cmd_done_evt = s_q.irq_req;
            end
        endcase

        // reason register; set wins over a same-cycle clear
        fault_rise = s_d.fault_valid && !s_q.fault_valid;
        set_lo[`RSN_SW_ERROR]  = fault_rise;
        set_lo[`RSN_CMD_DONE]  = cmd_done_evt;
        set_lo[`RSN_OCCUPANCY] = i_evt_occupancy;
        set_lo[`RSN_PERF_OVF]  = i_evt_perf_ovf;
        set_lo[`RSN_HALT]      = i_evt_halt && s_q.ien[`IEN_HALT];
        set_lo[`RSN_EVENT_LOG] = i_evt_event_log && s_q.ien[`IEN_EVENT_LOG];
        if (wr_reason) begin
            clr_lo = i_reg_wdata[`RSN_LOW_W-1:0];
        end
        s_d.reason_lo = (s_q.reason_lo & ~clr_lo) | set_lo;
        if (wr_reason && i_reg_wdata[`RSN_REVOKED]) begin
            s_d.reason_hi = 1'b0;
        end
        if (i_evt_revoked) begin
            s_d.reason_hi = 1'b1;
        end

        // only vector zero carries a reason
        any_new = cmd_done_evt
               || (fault_rise && s_q.ien[`IEN_SW_ERROR])
               || (|set_lo[`RSN_HALT:`RSN_OCCUPANCY])
               || set_lo[`RSN_EVENT_LOG]
               || i_evt_revoked;
        s_d.msix = any_new;

        // read path, answered one cycle later
        if (i_reg_rd) begin
            s_d.rvalid = 1'b1;
            s_d.rdata  = `ZERO_WORD;
            if (hit(i_reg_addr, `INTR_REASON_OFF)) begin
                s_d.rdata[`RSN_LOW_W-1:0] = s_q.reason_lo;
                s_d.rdata[`RSN_REVOKED]   = s_q.reason_hi;
            end else if (hit(i_reg_addr, `INTR_ENABLE_OFF)) begin
                s_d.rdata[`IEN_W-1:0] = s_q.ien;
            end else if (hit(i_reg_addr, `CMD_STATUS_OFF)) begin
                s_d.rdata[`STS_ACTIVE_BIT]  = s_q.active;
                s_d.rdata[`STS_ERR_W-1:0]   = s_q.err;
            end else if (hit(i_reg_addr, `FAULT_LOG_OFF)) begin
                s_d.rdata[`FAULT_VALID_BIT] = s_q.fault_valid;
                s_d.rdata[`FAULT_CODE_LO +: `STS_ERR_W] = s_q.fault_code;
            end
            // command word and unmapped offsets read as zero
        end
    end

    // ======================================================================
    // register stage
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            s_q           <= '0;
            s_q.seq       <= ST_IDLE;
            s_q.engine_op <= ENG_DRAIN_ALL;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================================
    // outputs, all straight from the state register
    assign o_reg_rdata      = s_q.rdata;
    assign o_reg_rvalid     = s_q.rvalid;
    assign o_engine_req     = s_q.engine_req;
    assign o_engine_op      = s_q.engine_op;
    assign o_wq_mask        = s_q.wq_mask;
    assign o_device_enabled = s_q.dev_en;
    assign o_wq_enabled     = s_q.wq_en;
    assign o_config_clear   = s_q.cfg_clear;
    assign o_msix0_req      = s_q.msix;

endmodule : admin_command_and_irq_cause
`default_nettype wire

/* File: drain_engine_model.sv */
// Purpose: far-side drain and abort engine seen by the command block
// Assumes: one clock, synchronous active-low reset
// Notes:   done comes i_delay plus one cycles after the request is sampled; zero is prompt
`timescale 1ns/1ps
`default_nettype none

module drain_engine_model (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    // request and answer
    input  wire logic       i_req,
    input  wire logic [7:0] i_delay,
    output var  logic       o_done
);
    logic [7:0] cnt_q;
    logic       run_q;

    // ======================================================================
    // done pulse only after a request, never spontaneous
    always_ff @(posedge i_clock) begin
        o_done <= 1'b0;
        if (!i_rstn) begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (i_req) begin
            run_q <= 1'b1;
            cnt_q <= i_delay;
        end else if (run_q) begin
            if (cnt_q == 8'h00) begin
                run_q  <= 1'b0;
                o_done <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : drain_engine_model
`default_nettype wire

/* File: admin_cmd_checker.sv */
// Purpose: port-level assertions for the admin command block
// Assumes: NUM_WQ of 16 for the group mask check
// Notes:   busy is modelled from the command timing
`timescale 1ns/1ps
`default_nettype none
`include "admin_cmd_map.svh"

module admin_cmd_checker
    import admin_cmd_pkg::*;
#(
    parameter int NUM_WQ = 16
) (
    // clock, reset, bus
    input  wire logic                   i_clock,
    input  wire logic                   i_rstn,
    input  wire logic                   i_reg_wr,
    input  wire logic                   i_reg_rd,
    input  wire logic [`REG_ADDR_W-1:0] i_reg_addr,
    input  wire logic [31:0]            i_reg_wdata,
    input  wire logic                   o_reg_rvalid,
    // events and engine
    input  wire logic                   i_evt_revoked,
    input  wire logic                   o_engine_req,
    input  wire engine_op_type          o_engine_op,
    input  wire logic [NUM_WQ-1:0]      o_wq_mask,
    input  wire logic                   i_engine_done,
    // state and interrupt
    input  wire logic                   o_device_enabled,
    input  wire logic [NUM_WQ-1:0]      o_wq_enabled,
    input  wire logic                   o_config_clear,
    input  wire logic                   o_msix0_req
);
    logic       busy_q;
    logic       eng_q;
    logic       irq_q;
    logic [1:0] cnt_q;
    wire        cw   = i_reg_wr && (i_reg_addr == `CMD_WORD_OFF);
    wire        acc  = cw && !busy_q;
    wire  [4:0] code = i_reg_wdata[24:20];
    wire        eng  = (code == 5'h03) || (code == 5'h04) || (code == 5'h08) || (code == 5'h09);

    // ======================================================================
    // busy model: two cycles for device codes, engine done plus one
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            busy_q <= 1'b0;
            eng_q  <= 1'b0;
            irq_q  <= 1'b0;
            cnt_q  <= 2'h0;
        end else if (acc) begin
            busy_q <= 1'b1;
            eng_q  <= eng;
            irq_q  <= i_reg_wdata[31];
            cnt_q  <= 2'h2;
        end else if (busy_q && !eng_q) begin
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                busy_q <= 1'b0;
            end
        end else if (busy_q && i_engine_done) begin
            eng_q <= 1'b0;
            cnt_q <= 2'h1;
        end
    end

    // ======================================================================
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);

    AST_READ_ANSWER: assert property (
        i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
    AST_ENABLE_DEV: assert property (
        acc && code == 5'h01 |=> ##1 o_device_enabled) else $error("enable missed");
    AST_DISABLE_DEV: assert property (
        acc && (code == 5'h02 || code == 5'h05) |=> ##1 !o_device_enabled && o_wq_enabled == '0)
        else $error("disable missed");
    AST_CFG_CLEAR: assert property (
        acc && code == 5'h05 |=> ##1 o_config_clear ##1 !o_config_clear)
        else $error("config clear pulse wrong");
    // code 4 differs from code 3 in bit 22
    AST_ALL_ENGINE: assert property (
        acc && (code == 5'h03 || code == 5'h04) |=> ##1 o_engine_req && &o_wq_mask
        && !o_engine_op[1] && o_engine_op[0] == $past(i_reg_wdata[22], 2))
        else $error("all-queue engine request wrong");
    // group 0 holds every queue when NUM_WQ is 16
    AST_WQ_ENGINE: assert property (
        acc && (code == 5'h08 || code == 5'h09) |=> ##1 o_engine_req && o_engine_op[1]
        && o_engine_op[0] == $past(i_reg_wdata[20], 2)
        && o_wq_mask == NUM_WQ'($past(i_reg_wdata[19:16], 2) == 4'h0
            ? $past(i_reg_wdata[15:0], 2) : 16'h0000))
        else $error("queue engine request wrong");
    AST_WQ_ENABLE: assert property (
        acc && code == 5'h06 && i_reg_wdata[7:0] < NUM_WQ
        |=> ##1 o_wq_enabled[$past(i_reg_wdata[3:0], 2)]) else $error("queue enable missed");
    AST_IGNORED: assert property (
        busy_q && cw |=> ##1 !o_engine_req && $stable(o_device_enabled))
        else $error("command taken while active");
    AST_DEV_IRQ: assert property (
        acc && i_reg_wdata[31] && !eng |=> ##2 o_msix0_req) else $error("completion irq missed");
    AST_ENG_IRQ: assert property (
        busy_q && eng_q && irq_q && i_engine_done |=> ##1 o_msix0_req)
        else $error("engine completion irq missed");
    AST_REVOKED_IRQ: assert property (
        i_evt_revoked |=> o_msix0_req) else $error("revoked irq missed");
endmodule : admin_cmd_checker

bind admin_command_and_irq_cause admin_cmd_checker #(.NUM_WQ(NUM_WQ)) i_admin_cmd_checker (
    .i_clock(i_clock), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rvalid(o_reg_rvalid),
    .i_evt_revoked(i_evt_revoked), .o_engine_req(o_engine_req), .o_engine_op(o_engine_op),
    .o_wq_mask(o_wq_mask), .i_engine_done(i_engine_done), .o_device_enabled(o_device_enabled),
    .o_wq_enabled(o_wq_enabled), .o_config_clear(o_config_clear), .o_msix0_req(o_msix0_req));
`default_nettype wire

/* File: admin_command_and_irq_cause_tb_top.sv */
// Purpose: self-checking bench for the admin command block
// Assumes: NUM_WQ of 16, engine delay set per test
// Notes:   events stay quiet while commands run, so irq counts are exact
`timescale 1ns/1ps
`default_nettype none
`include "admin_cmd_map.svh"

module admin_command_and_irq_cause_tb_top;
    logic        i_clock = 1'b0;
    logic        i_rstn = 1'b0;
    logic        i_reg_wr = 1'b0;
    logic        i_reg_rd = 1'b0;
    logic [11:0] i_reg_addr = 12'h000;
    logic [31:0] i_reg_wdata = 32'h0;
    logic [31:0] o_reg_rdata;
    logic        o_reg_rvalid;
    logic [4:0]  evt = 5'h00;
    logic        o_engine_req;
    logic        i_engine_done;
    logic [7:0]  eng_delay = 8'h00;
    logic        o_device_enabled;
    logic [15:0] o_wq_enabled;
    logic        o_msix0_req;
    logic [31:0] s;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          msix_cnt = 0;
    int          m;
    logic [31:0] cmds [11] = '{32'h8010_0000, 32'h8060_0005, 32'h8060_0003, 32'h8080_00a0,
        32'h8091_0008, 32'h8070_0020, 32'h8030_0000, 32'h8040_0000, 32'h8020_0000,
        32'h8010_0000, 32'h8050_0000};
    logic        exp_dev [11] = '{1, 1, 1, 1, 1, 1, 1, 1, 0, 1, 0};
    logic [15:0] exp_wq [11] = '{16'h0000, 16'h0020, 16'h0028, 16'h0028, 16'h0028,
        16'h0008, 16'h0008, 16'h0008, 16'h0000, 16'h0000, 16'h0000};

    always #20 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        if (o_msix0_req === 1'b1) begin
            msix_cnt++;
        end
    end

    admin_command_and_irq_cause i_admin_command_and_irq_cause (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .i_evt_event_log(evt[0]), .i_evt_halt(evt[1]),
        .i_evt_perf_ovf(evt[2]), .i_evt_occupancy(evt[3]), .i_evt_revoked(evt[4]),
        .o_engine_req(o_engine_req), .o_engine_op(), .o_wq_mask(),
        .i_engine_done(i_engine_done), .o_device_enabled(o_device_enabled),
        .o_wq_enabled(o_wq_enabled), .o_config_clear(), .o_msix0_req(o_msix0_req));

    drain_engine_model i_drain_engine_model (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_req(o_engine_req),
        .i_delay(eng_delay), .o_done(i_engine_done));

    // ======================================================================
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        #1;
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(posedge i_clock);
        #1;
        i_reg_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_clock);
        #1;
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(posedge i_clock);
        #1;
        i_reg_rd = 1'b0;
        d = o_reg_rdata;
        chk("rvalid", 32'h1, {31'h0, o_reg_rvalid});
    endtask : rd

    // poll active after a command until it clears; bounded so a stuck flag fails
    task automatic wait_idle;
        for (int i = 0; i < 64; i++) begin
            rd(`CMD_STATUS_OFF, s);
            if (s[31] === 1'b0) begin
                break;
            end
        end
        chk("active", 32'h0, {31'h0, s[31]});
    endtask : wait_idle

    task automatic pulse_all;
        for (int k = 0; k < 5; k++) begin
            @(posedge i_clock);
            #1;
            evt = 5'h01 << k;
            @(posedge i_clock);
            #1;
            evt = 5'h00;
        end
        repeat (3) @(posedge i_clock);
    endtask : pulse_all

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // ======================================================================
    initial begin
        repeat (20000) @(posedge i_clock);
        error_cnt++;
        print_verdict();
    end

    initial begin
        repeat (8) @(posedge i_clock);
        #1;
        i_rstn = 1'b1;
        rd(`INTR_REASON_OFF, s);
        chk("reason reset", 32'h0, s);
        rd(12'h0f0, s);
        chk("unmapped", 32'h0, s);
        // command while active: slow engine keeps the first one running
        eng_delay = 8'd20;
        wr(`CMD_WORD_OFF, 32'h0030_0000);
        rd(`CMD_STATUS_OFF, s);
        chk("active set", 32'h1, {31'h0, s[31]});
        wr(`CMD_WORD_OFF, 32'h0010_0000);
        wait_idle();
        chk("ignored enable", 32'h0, {31'h0, o_device_enabled});
        rd(`FAULT_LOG_OFF, s);
        chk("fault log", 32'h0101, {16'h0, s[15:0]});
        wr(`INTR_REASON_OFF, 32'h0);
        rd(`INTR_REASON_OFF, s);
        chk("sw error reason", 32'h1, s);
        chk("no irq", 32'h0, msix_cnt);
        wr(`FAULT_LOG_OFF, 32'h1);
        wr(`INTR_REASON_OFF, 32'hffff_ffff);
        rd(`INTR_REASON_OFF, s);
        chk("reason cleared", 32'h0, s);
        // undefined codes
        for (int i = 0; i < 3; i++) begin
            wr(`CMD_WORD_OFF, {7'h0, 5'(i * 11), 20'h0});
            wait_idle();
            chk("unsupported", 32'h01, {24'h0, s[7:0]});
        end
        // every supported code, prompt and slow engine, completion irq
        foreach (cmds[i]) begin
            eng_delay = (i % 2 == 0) ? 8'd0 : 8'd12;
            m = msix_cnt;
            wr(`CMD_WORD_OFF, cmds[i]);
            wait_idle();
            chk("status ok", 32'h0, {24'h0, s[7:0]});
            chk("dev enabled", {31'h0, exp_dev[i]}, {31'h0, o_device_enabled});
            chk("wq enabled", {16'h0, exp_wq[i]}, {16'h0, o_wq_enabled});
            chk("completion irq", m + 1, msix_cnt);
            rd(`INTR_REASON_OFF, s);
            chk("done reason", 32'h2, s);
            wr(`INTR_REASON_OFF, 32'h2);
        end
        // events: halt and event log need their enables
        m = msix_cnt;
        pulse_all();
        rd(`INTR_REASON_OFF, s);
        chk("event reason", 32'h8000_000c, s);
        chk("event irq", m + 3, msix_cnt);
        wr(`INTR_ENABLE_OFF, 32'h6);
        pulse_all();
        rd(`INTR_REASON_OFF, s);
        chk("enabled reason", 32'h8000_003c, s);
        chk("enabled irq", m + 8, msix_cnt);
        wr(`INTR_REASON_OFF, 32'h8000_0030);
        rd(`INTR_REASON_OFF, s);
        chk("partial clear", 32'h0000_000c, s);
        print_verdict();
    end
endmodule : admin_command_and_irq_cause_tb_top
`default_nettype wire
